// file: psa_pkg.sv
`default_nettype none
package psa_pkg;
  // ***************************************************************
  // register map, byte addresses on the apb port
  // ***************************************************************
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_STAT  = 8'h04;
  localparam logic [7:0] OFF_ERR   = 8'h08;
  localparam logic [7:0] OFF_IST   = 8'h0c;
  localparam logic [7:0] OFF_IMASK = 8'h10;
  localparam logic [7:0] OFF_ABS   = 8'h14;
  localparam logic [7:0] OFF_FUNC  = 8'h18;
  // ***************************************************************
  // field positions and reset values
  // ***************************************************************
  localparam int CTRL_P1_LSB  = 8;   // auto-start program number
  localparam int CTRL_POS_BIT = 16;  // positioner mode
  localparam int CTRL_SWR_BIT = 31;  // software restart, self clearing
  localparam int ABS_GO_BIT   = 8;
  localparam int FUNC_IDX_LSB = 24;
  localparam logic [7:0] P7_RST   = 8'h01; // auto start on
  localparam logic [7:0] P7_AUTO  = 8'h01;
  localparam logic [2:0] SYNC_SETTLE = 3'h4; // edges until a pin has crossed the synchroniser
  localparam logic [4:0] FN_AUTO  = 5'h05; // auto-start program signal
  localparam logic [4:0] DED_PORTS = 5'h18;  // 30..45 and 251..258
  // ***************************************************************
  // display and error codes
  // ***************************************************************
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_BATT = 16'heca2;
  localparam logic [15:0] ERR_ENC  = 16'he914;
  localparam logic [15:0] ERR_ABSC = 16'h0c70;
  localparam logic [15:0] ERR_HOME = 16'h0c6f;
  localparam logic [15:0] SEG_RDY_PROG = 16'h0d01; // arbitrary pattern code
  localparam logic [15:0] SEG_RDY_POS  = 16'h0d02; // arbitrary pattern code
  // interrupt status bits
  localparam int IB_START = 0;
  localparam int IB_AUTO  = 1;
  localparam int IB_ERR   = 2;
  localparam int IB_ABS   = 3;
  localparam int IB_ABORT = 4;
  // absolute reset steps, one-hot, in mandatory order
  typedef enum logic [4:0] {
    AB_RD1  = 5'b00001,
    AB_ERST = 5'b00010,
    AB_SON  = 5'b00100,
    AB_HOME = 5'b01000,
    AB_RD2  = 5'b10000
  } psa_abs_t;
endpackage
`default_nettype wire

// file: psa_mem_if.sv
`default_nettype none
interface psa_mem_if;
  logic       wr;
  logic [4:0] waddr;
  logic [4:0] wdata;
  logic [4:0] raddr;
  logic [4:0] rdata;
  modport ctl (output wr, waddr, wdata, raddr, input rdata);
  modport mem (input wr, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

// file: psa_sync.sv
`default_nettype none
module psa_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1_q, s2_q, s3_q;
  // ***************************************************************
  // three stages; a change counts once stages two and three agree
  // ***************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q    <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q    <= (s2_q & s3_q) | (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q);
    end
  end
endmodule // psa_sync
`default_nettype wire

// file: psa_fmem.sv
`default_nettype none
module psa_fmem #(
  parameter int DEPTH = 24
) (
  input wire logic clk,
  psa_mem_if.mem   m
);
  logic [4:0] mem_q [DEPTH];
  // ***************************************************************
  // per-port function values; read data registered, no reset on purpose
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (m.wr) begin
      mem_q[m.waddr] <= m.wdata;
    end
    m.rdata <= mem_q[m.raddr];
  end
endmodule // psa_fmem
`default_nettype wire

// file: psa_top.sv
// Functional notes
// - ready output and green lamp go on when program starts can be accepted.
// - start on input 0 runs the program selected by the bcd number.
// - emergency stop or controller error removes servo power and drops ready.
// - auto-start setting 1 in auto mode starts stored program after any reset.
// - port with function 5 starts auto program on rise, aborts on fall.
// - functions assignable only to ports 30-45 and 251-258, per-port value.
// - battery fault or cable loss raises encoder error code eca2 or e914.
// - absolute reset order: data reset 1, error reset, servo on, home, reset 2.
// - running after absolute reset without restart reports c70 or c6f; only the start input is checked, a function 5 port still starts.
// - after clean restart display shows ready, distinct for program/positioner.
//
// Local design decisions: the address map and the APB slave port.
`default_nettype none
module psa_top
  import psa_pkg::*;
#(
  parameter int NDED = 24
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        start_in,
  input  wire logic [6:0]  prog_bcd,
  input  wire logic [23:0] ded_in,
  input  wire logic        estop_in,
  input  wire logic        batt_low_in,
  input  wire logic        enc_disc_in,
  input  wire logic        mode_auto_in,
  input  wire logic        ctrl_err_in,
  input  wire logic        prog_end,
  input  wire logic        abs_done,
  output var  logic        ready_out,
  output var  logic        ready_lamp,
  output var  logic        servo_pwr,
  output var  logic        run_go,
  output var  logic        run_abort,
  output var  logic [6:0]  run_prog,
  output var  logic [4:0]  abs_step,
  output var  logic [2:0]  abs_axis,
  output var  logic [15:0] seg_code,
  output var  logic        irq
);
  typedef struct packed {
    logic        ready;
    logic        servo;
    logic        running;
    logic        by_port;
    logic        go;
    logic        abort;
    logic [6:0]  prog;
    logic        boot;
    logic [2:0]  settle;
    logic [7:0]  p7;
    logic [6:0]  p1;
    logic        pos_mode;
    logic [15:0] err;
    logic [4:0]  ist;
    logic [4:0]  imask;
    logic        irq;
    psa_abs_t    abs;
    logic        abs_wait;
    logic        abs_pend;
    logic [2:0]  axis;
    logic [4:0]  step;
    logic        start_prev;
    logic [23:0] ded_prev;
    logic [4:0]  scan;
    logic [4:0]  scan_dq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] seg;
  } psa_st_t;

  psa_st_t   st_q, st_d;
  psa_mem_if mif ();
  logic [35:0] pin_s;
  logic        start_s, estop_s, batt_s, enc_s, auto_s;
  logic [6:0]  bcd_s;
  logic [23:0] ded_s;
  logic        apb_acc, wr_acc, ready_ok, start_rise, ded_now, ded_old, auto_hit;
  logic [6:0]  bcd_bin;

  // ***************************************************************
  // pin synchronisers and function table
  // ***************************************************************
  psa_sync #(.W(36)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({start_in, prog_bcd, ded_in, estop_in, batt_low_in, enc_disc_in, mode_auto_in}),
    .q   (pin_s)
  );
  assign {start_s, bcd_s, ded_s, estop_s, batt_s, enc_s, auto_s} = pin_s;

  psa_fmem #(.DEPTH(NDED)) u_fmem (
    .clk (clk),
    .m   (mif.mem)
  );

  // table write on an accepted func access, scan read runs freely
  assign mif.wr    = wr_acc && (paddr == OFF_FUNC);
  assign mif.waddr = pwdata[FUNC_IDX_LSB +: 5];
  assign mif.wdata = pwdata[4:0];
  assign mif.raddr = st_q.scan;

  // ***************************************************************
  // helper terms
  // ***************************************************************
  assign apb_acc    = psel && penable && st_q.pready;
  assign wr_acc     = apb_acc && pwrite && !st_q.pslverr;
  assign bcd_bin    = ({4'h0, bcd_s[6:4]} * 7'd10) + {3'h0, bcd_s[3:0]};
  assign start_rise = start_s && !st_q.start_prev;
  // any fault keeps the block from taking starts
  assign ready_ok   = !estop_s && !ctrl_err_in && (st_q.err == ERR_NONE) && !st_q.abs_wait
                      && (st_q.settle == SYNC_SETTLE);
  assign ded_now    = ded_s[st_q.scan_dq];
  assign ded_old    = st_q.ded_prev[st_q.scan_dq];
  assign auto_hit   = (mif.rdata == FN_AUTO);

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    st_d            = st_q;
    st_d.go         = 1'b0;
    st_d.abort      = 1'b0;
    st_d.step       = 5'h00;
    st_d.pready     = 1'b0;
    st_d.start_prev = start_s;
    st_d.ready      = ready_ok;
    // scan walks the table; data arrive a cycle after the address
    st_d.scan       = (st_q.scan == DED_PORTS - 5'h01) ? 5'h00 : st_q.scan + 5'h01;
    st_d.scan_dq    = st_q.scan;
    st_d.settle     = (st_q.settle == SYNC_SETTLE) ? st_q.settle : st_q.settle + 3'h1;
    st_d.ded_prev[st_q.scan_dq] = ded_now;

    // fault removes servo and stops any program
    if (estop_s || ctrl_err_in) begin
      st_d.servo = 1'b0;
      if (st_q.running) begin
        st_d.running = 1'b0;
        st_d.abort   = 1'b0 | 1'b1;
        st_d.ist[IB_ABORT] = 1'b1;
      end
    end else if (st_q.running && prog_end) begin
      st_d.running = 1'b0;
    end

    // start request; number sampled only at this edge
    if (start_rise && st_q.ready && !st_q.running) begin
      if (st_q.abs_pend || st_q.abs != AB_RD1) begin
        st_d.err = st_q.abs_pend ? ERR_ABSC : ERR_HOME;
      end else if (bcd_s[3:0] <= 4'h9) begin
        st_d.prog    = bcd_bin;
        st_d.running = 1'b1;
        st_d.by_port = 1'b0;
        st_d.go      = 1'b1;
        st_d.ist[IB_START] = 1'b1;
      end
    end

    // port with auto-start function: rise starts, fall aborts
    if (auto_hit && ded_now && !ded_old && st_q.ready && !st_q.running) begin
      st_d.prog    = st_q.p1;
      st_d.running = 1'b1;
      st_d.by_port = 1'b1;
      st_d.go      = 1'b1;
      st_d.ist[IB_AUTO] = 1'b1;
    end else if (auto_hit && !ded_now && ded_old && st_q.running && st_q.by_port) begin
      st_d.running = 1'b0;
      st_d.abort   = 1'b1;
      st_d.ist[IB_ABORT] = 1'b1;
    end

    // after any reset, auto start once ready in auto mode
    if (st_q.boot && st_q.ready) begin
      st_d.boot = 1'b0;
      if (st_q.p7 == P7_AUTO && auto_s && !st_q.running) begin
        st_d.prog    = st_q.p1;
        st_d.running = 1'b1;
        st_d.by_port = 1'b0;
        st_d.go      = 1'b1;
        st_d.ist[IB_AUTO] = 1'b1;
      end
    end

    // absolute reset step finished, move to the next in fixed order
    if (st_q.abs_wait && abs_done) begin
      st_d.abs_wait    = 1'b0;
      st_d.ist[IB_ABS] = 1'b1;
      unique case (st_q.abs)
        AB_RD1:  st_d.abs = AB_ERST;
        AB_ERST: st_d.abs = AB_SON;
        AB_SON:  st_d.abs = AB_HOME;
        AB_HOME: st_d.abs = AB_RD2;
        AB_RD2: begin
          // servo stays on through reset 2, the servo-off step is skipped
          st_d.abs      = AB_RD1;
          st_d.abs_pend = 1'b1;
        end
      endcase
    end

    // ***************************************************************
    // apb setup phase: decode and register the answer
    // ***************************************************************
    if (psel && !penable) begin
      st_d.pready  = 1'b1;
      st_d.pslverr = 1'b0;
      st_d.prdata  = 32'h0000_0000;
      unique case (paddr)
        OFF_CTRL:  st_d.prdata = {15'h0000, st_q.pos_mode, 1'b0, st_q.p1, st_q.p7};
        OFF_STAT:  st_d.prdata = {14'h0000, st_q.abs, st_q.abs_pend, st_q.abs_wait,
                                  st_q.prog, st_q.by_port, st_q.running, st_q.servo, st_q.ready};
        OFF_ERR:   st_d.prdata = {16'h0000, st_q.err};
        OFF_IST:   st_d.prdata = {27'h0000000, st_q.ist};
        OFF_IMASK: st_d.prdata = {27'h0000000, st_q.imask};
        OFF_ABS:   st_d.prdata = {29'h00000000, st_q.axis};
        // only the dedicated port range takes a function value
        OFF_FUNC:  st_d.pslverr = pwrite && (pwdata[FUNC_IDX_LSB +: 5] >= DED_PORTS);
        default:   st_d.pslverr = 1'b1;
      endcase
    end

    // ***************************************************************
    // apb access phase: writes take effect here
    // ***************************************************************
    if (wr_acc) begin
      unique case (paddr)
        OFF_CTRL: begin
          st_d.p7       = pwdata[7:0];
          st_d.p1       = pwdata[CTRL_P1_LSB +: 7];
          st_d.pos_mode = pwdata[CTRL_POS_BIT];
          if (pwdata[CTRL_SWR_BIT]) begin
            // restart: stop, clear errors, rearm auto start
            st_d.boot     = 1'b1;
            st_d.running  = 1'b0;
            st_d.abort    = st_q.running;
            st_d.abs_pend = 1'b0;
            st_d.err      = ERR_NONE;
          end
        end
        OFF_ERR:   st_d.err   = ERR_NONE;
        OFF_IST:   st_d.ist   = st_d.ist & ~(pwdata[4:0] & ~(st_d.ist ^ st_q.ist)) | (st_d.ist & ~st_q.ist);
        OFF_IMASK: st_d.imask = pwdata[4:0];
        OFF_ABS: begin
          if (pwdata[ABS_GO_BIT] && !st_q.abs_wait) begin
            st_d.axis     = pwdata[2:0];
            st_d.step     = st_q.abs;
            st_d.abs_wait = 1'b1;
            if (st_q.abs == AB_ERST) begin
              st_d.err = ERR_NONE;
            end
            if (st_q.abs == AB_SON) begin
              st_d.servo = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end

    // encoder faults win over any clear in the same cycle
    if (batt_s) begin
      st_d.err = ERR_BATT;
    end else if (enc_s) begin
      st_d.err = ERR_ENC;
    end
    if (st_d.err != ERR_NONE && st_q.err == ERR_NONE) begin
      st_d.ist[IB_ERR] = 1'b1;
    end
    // a servo-on step in the same cycle as a fault must not win
    if (estop_s || ctrl_err_in) begin
      st_d.servo = 1'b0;
    end

    // display: error code first, else ready pattern for the mode
    st_d.seg = (st_q.err != ERR_NONE) ? st_q.err :
               (st_q.pos_mode ? SEG_RDY_POS : SEG_RDY_PROG);
    st_d.irq = |(st_d.ist & st_q.imask);
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q      <= '0;
      st_q.boot <= 1'b1;
      st_q.p7   <= P7_RST;
      st_q.abs  <= AB_RD1;
      st_q.seg  <= SEG_RDY_PROG;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state flops
  assign prdata     = st_q.prdata;
  assign pready     = st_q.pready;
  assign pslverr    = st_q.pslverr;
  assign ready_out  = st_q.ready;
  assign ready_lamp = st_q.ready;
  assign servo_pwr  = st_q.servo;
  assign run_go     = st_q.go;
  assign run_abort  = st_q.abort;
  assign run_prog   = st_q.prog;
  assign abs_step   = st_q.step;
  assign abs_axis   = st_q.axis;
  assign seg_code   = st_q.seg;
  assign irq        = st_q.irq;

  // ***************************************************************
  // checks
  // ***************************************************************
  ready_drop_a: assert property (@(posedge clk) disable iff (rst)
    (estop_s || ctrl_err_in) |=> !ready_out && !ready_lamp)
    else $error("ready not dropped on fault");
  servo_off_a: assert property (@(posedge clk) disable iff (rst)
    estop_s |=> !servo_pwr)
    else $error("servo still powered under emergency stop");
  start_num_a: assert property (@(posedge clk) disable iff (rst)
    run_go && !$past(st_q.boot) && !$past(auto_hit) |-> run_prog == $past(bcd_bin))
    else $error("started program differs from sampled number");
  num_hold_a: assert property (@(posedge clk) disable iff (rst)
    st_q.running && !run_go |=> $stable(run_prog) || run_go)
    else $error("program number changed while running");
  auto_boot_a: assert property (@(posedge clk) disable iff (rst)
    st_q.boot && st_q.ready && st_q.p7 == P7_AUTO && auto_s && !st_q.running
    |=> run_go && run_prog == $past(st_q.p1))
    else $error("auto start missing after reset");
  batt_err_a: assert property (@(posedge clk) disable iff (rst)
    batt_s |=> ##1 seg_code == ERR_BATT)
    else $error("battery error not shown");
  abs_order_a: assert property (@(posedge clk) disable iff (rst)
    abs_step != 5'h00 |-> abs_step == $past(st_q.abs) && $onehot(abs_step))
    else $error("absolute reset step out of order");
  abs_c70_a: assert property (@(posedge clk) disable iff (rst)
    st_q.abs_pend && start_rise && st_q.ready && !st_q.running && !batt_s && !enc_s
    && !wr_acc |=> st_q.err == ERR_ABSC && !run_go)
    else $error("start after absolute reset not reported");
  port_abort_a: assert property (@(posedge clk) disable iff (rst)
    auto_hit && !ded_now && ded_old && st_q.running && st_q.by_port |=> run_abort)
    else $error("auto-start port fall did not abort");
  seg_ready_a: assert property (@(posedge clk) disable iff (rst)
    st_q.err == ERR_NONE ##1 st_q.err == ERR_NONE
    |-> seg_code == (st_q.pos_mode ? SEG_RDY_POS : SEG_RDY_PROG) || $changed(st_q.pos_mode))
    else $error("ready pattern wrong for mode");
endmodule // psa_top
`default_nettype wire

// file: psa_host.sv
`default_nettype none
// ***************************************************************
// host controller model: drives the start, number and port pins
// ***************************************************************
module psa_host #(
  parameter int T_RDY   = 4,  // gaps scaled down from milliseconds
  parameter int T_NUM   = 8,  // so the run stays short
  parameter int T_START = 16
) (
  input  wire logic        clk,
  input  wire logic        ready,
  output var  logic        start_in,
  output var  logic [6:0]  prog_bcd,
  output var  logic [23:0] ded_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins idle low until the bench asks for traffic
  initial begin
    start_in = 1'b0;
    prog_bcd = 7'h00;
    ded_in   = 24'h000000;
  end
  // one external start; goes ahead even if ready never shows, so refusals can be seen
  task start_prog(input int num);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    repeat (T_RDY) @(posedge clk);
    prog_bcd <= {3'(num / 10), 4'(num % 10)};
    repeat (T_NUM) @(posedge clk);
    start_in <= 1'b1;
    repeat (T_START) @(posedge clk);
    start_in <= 1'b0;
  endtask
  // level change on one dedicated port
  task set_port(input int idx, input logic v);
    @(posedge clk);
    ded_in[idx] <= v;
  endtask
endmodule // psa_host
`default_nettype wire

// file: psa_tb_top.sv
`default_nettype none
module psa_tb_top
  import psa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, start_in;
  logic        estop_in, batt_low_in, enc_disc_in, mode_auto_in, ctrl_err_in;
  logic        prog_end, abs_done, ready_out, ready_lamp, servo_pwr, run_go;
  logic        run_abort, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  prog_bcd, run_prog;
  logic [23:0] ded_in;
  logic [4:0]  abs_step, st_val;
  logic [2:0]  abs_axis;
  logic [15:0] seg_code;
  int          num_errors, checks, cyc, go_cnt, ab_cnt, st_cnt, k;
  psa_top u_psa_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_in(start_in), .prog_bcd(prog_bcd), .ded_in(ded_in), .estop_in(estop_in),
    .batt_low_in(batt_low_in), .enc_disc_in(enc_disc_in), .mode_auto_in(mode_auto_in),
    .ctrl_err_in(ctrl_err_in), .prog_end(prog_end), .abs_done(abs_done), .ready_out(ready_out),
    .ready_lamp(ready_lamp), .servo_pwr(servo_pwr), .run_go(run_go), .run_abort(run_abort),
    .run_prog(run_prog), .abs_step(abs_step), .abs_axis(abs_axis), .seg_code(seg_code), .irq(irq));
  psa_host u_psa_host (.clk(clk), .ready(ready_out), .start_in(start_in), .prog_bcd(prog_bcd),
    .ded_in(ded_in));
  // ***************************************************************
  // clock, event monitors and hang guard
  // ***************************************************************
  always #10 clk = ~clk;
  // pulses last one cycle, so they are counted at the edge that sees them
  always @(posedge clk) begin
    cyc++;
    if (run_go === 1'b1) go_cnt++;
    if (run_abort === 1'b1) ab_cnt++;
    if (abs_step !== 5'h00) begin
      st_cnt++;
      st_val = abs_step;
    end
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  // ***************************************************************
  // helpers
  // ***************************************************************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held until pready is sampled high at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded wait for a monitor count to move past prev
  task automatic wcnt(ref int c, input int prev);
    int n;
    n = 0;
    while (c == prev && n < 300) begin
      @(posedge clk);
      n++;
    end
  endtask
  task pulse_end(input logic done);
    @(posedge clk);
    if (done) abs_done <= 1'b1;
    else prog_end <= 1'b1;
    @(posedge clk);
    abs_done <= 1'b0;
    prog_end <= 1'b0;
  endtask
  task summarize();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    {clk, psel, penable, pwrite, estop_in, batt_low_in, enc_disc_in} = '0;
    {ctrl_err_in, prog_end, abs_done, num_errors, checks, cyc} = '0;
    {go_cnt, ab_cnt, st_cnt} = '0;
    {paddr, pwdata} = '0;
    mode_auto_in = 1'b1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // boot with auto start on runs the stored number
    wcnt(go_cnt, 0);
    chk("auto go", 1, go_cnt);
    chk("auto prog", 0, run_prog);
    chk("ready", 1, {ready_out, ready_lamp} == 2'b11);
    mode_auto_in <= 1'b0;
    pulse_end(1'b0);
    apb(1'b0, OFF_CTRL, 0);
    chk("ctrl rst", 32'h1, rd);
    apb(1'b0, 8'h1c, 0);
    chk("unmapped", 1, err);
    // external start with interrupt on the start event
    apb(1'b1, OFF_IMASK, 32'h1);
    u_psa_host.start_prog(42);
    chk("go", 2, go_cnt);
    chk("prog", 42, run_prog);
    chk("irq set", 1, irq);
    u_psa_host.start_prog(13);
    chk("busy go", 2, go_cnt);
    chk("busy prog", 42, run_prog);
    apb(1'b1, OFF_IST, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq clr", 0, irq);
    apb(1'b1, OFF_IMASK, 32'h0);
    pulse_end(1'b0);
    // auto program on a dedicated port
    apb(1'b1, OFF_CTRL, 32'h700);
    apb(1'b1, OFF_FUNC, 32'h18000005);
    chk("func idx", 1, err);
    apb(1'b1, OFF_FUNC, 32'h03000005);
    chk("func ok", 0, err);
    u_psa_host.set_port(3, 1'b1);
    wcnt(go_cnt, 2);
    chk("port prog", 7, run_prog);
    u_psa_host.set_port(3, 1'b0);
    wcnt(ab_cnt, 0);
    chk("port abort", 1, ab_cnt);
    // emergency stop during a run
    u_psa_host.start_prog(5);
    estop_in <= 1'b1;
    wcnt(ab_cnt, 1);
    repeat (10) @(posedge clk);
    chk("estop", 0, {ready_out, ready_lamp, servo_pwr});
    estop_in <= 1'b0;
    // battery and cable faults
    batt_low_in <= 1'b1;
    repeat (10) @(posedge clk);
    apb(1'b0, OFF_ERR, 0);
    chk("batt", ERR_BATT, rd);
    chk("seg batt", ERR_BATT, seg_code);
    batt_low_in <= 1'b0;
    enc_disc_in <= 1'b1;
    repeat (10) @(posedge clk);
    apb(1'b0, OFF_ERR, 0);
    chk("enc", ERR_ENC, rd);
    enc_disc_in <= 1'b0;
    repeat (10) @(posedge clk);
    apb(1'b1, OFF_ERR, 0);
    // absolute reset steps, with a start tried part way and at the end
    for (k = 0; k < 5; k++) begin
      apb(1'b1, OFF_ABS, 32'h102);
      wcnt(st_cnt, k);
      chk("step", 32'h1 << k, st_val);
      chk("axis", 2, abs_axis);
      if (k == 2) chk("servo on", 1, servo_pwr);
      pulse_end(1'b1);
      if (k == 0) begin
        repeat (10) @(posedge clk);
        u_psa_host.start_prog(3);
        apb(1'b0, OFF_ERR, 0);
        chk("home err", ERR_HOME, rd);
      end
    end
    repeat (10) @(posedge clk);
    u_psa_host.start_prog(3);
    apb(1'b0, OFF_ERR, 0);
    chk("abs err", ERR_ABSC, rd);
    chk("no go", 4, go_cnt);
    // restart clears the fault and shows the mode pattern
    apb(1'b1, OFF_CTRL, 32'h80000000);
    repeat (20) @(posedge clk);
    chk("seg prog", SEG_RDY_PROG, seg_code);
    apb(1'b1, OFF_CTRL, 32'h10000);
    repeat (5) @(posedge clk);
    chk("seg pos", SEG_RDY_POS, seg_code);
    summarize();
  end
endmodule // psa_tb_top
`default_nettype wire
